// ### rtl/pic_pkg.sv
// Constants and types for the proximity interrupt and configuration logic
package pic_pkg;

    // Register byte addresses
    localparam logic [7:0] PIC_ADDR_MODE_SLEEP = 8'h96;
    localparam logic [7:0] PIC_ADDR_ROUTING = 8'h97;
    localparam logic [7:0] PIC_ADDR_PERSIST = 8'h9A;
    localparam logic [7:0] PIC_ADDR_CONTROL = 8'hA0;
    localparam logic [7:0] PIC_ADDR_STATUS = 8'hA1;
    localparam logic [7:0] PIC_ADDR_LOW_THR_LO = 8'hA2;
    localparam logic [7:0] PIC_ADDR_LOW_THR_HI = 8'hA3;
    localparam logic [7:0] PIC_ADDR_HIGH_THR_LO = 8'hA4;
    localparam logic [7:0] PIC_ADDR_HIGH_THR_HI = 8'hA5;
    localparam logic [7:0] PIC_ADDR_RESULT_LO = 8'hA6;
    localparam logic [7:0] PIC_ADDR_RESULT_HI = 8'hA7;

    // Field positions
    localparam int PIC_HXTALK_A_BIT = 5;
    localparam int PIC_SLEEP_EN_BIT = 4;
    localparam int PIC_IRQ_SEL_LSB = 4;
    localparam int PIC_AUX_SEL_LSB = 0;
    localparam int PIC_PROXIMITY_PERSISTENCE_COUNT_LSB = 4;
    localparam int PIC_APERS_LSB = 0;
    localparam int PIC_HXTALK_B_BIT = 0;
    localparam int PIC_PROX_IEN_BIT = 1;
    localparam int PIC_ST_PROX_BIT = 0;
    localparam int PIC_ST_AMB_BIT = 1;
    localparam int PIC_ST_SLEEP_BIT = 2;

    // Reset values
    localparam logic [3:0] PIC_MODE_RSVD_VAL = 4'hF;
    localparam logic [1:0] PIC_MODE_TOP_VAL = 2'h0;
    localparam logic [3:0] PIC_SEL_RESET = 4'h0;
    localparam logic [3:0] PIC_PROXIMITY_PERSISTENCE_COUNT_RESET = 4'h1;
    localparam logic [3:0] PIC_APERS_RESET = 4'h1;
    localparam logic [15:0] PIC_LOW_THR_RESET = 16'h0000;
    localparam logic [15:0] PIC_HIGH_THR_RESET = 16'hFFFF;
    localparam logic [7:0] PIC_RDATA_IDLE = 8'h00;

    // Pin map codes; all others are reserved
    typedef enum logic [3:0]
    {
        PIC_PIN_NORMAL = 4'h0,
        PIC_PIN_AMB_DIRECT = 4'h2,
        PIC_PIN_PROX_DIRECT = 4'h3,
        PIC_PIN_INVERTED_A = 4'h4,
        PIC_PIN_INVERTED_B = 4'h5,
        PIC_PIN_EMITTER = 4'h6
    } pic_pin_sel_e;

    // Oscillator sleep state
    typedef enum logic
    {
        PIC_RUN = 1'b0,
        PIC_SLEEP = 1'b1
    } pic_sleep_e;

endpackage

// ### rtl/pic_persist.sv
// Proximity persistence filter: counts consecutive out-of-range samples
module pic_persist
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_sample_valid,
    input wire logic i_out_of_range,
    input wire logic [3:0] i_limit,
    output logic o_fire
);

    logic [3:0] count_q;
    logic [3:0] count_d;
    logic fire_d;

    always_comb
    begin
        count_d = count_q;
        fire_d = 1'b0;
        if (i_sample_valid)
        begin
            if (i_limit == 4'h0)
            begin
                fire_d = 1'b1; // R9
            end
            if (!i_out_of_range)
            begin
                count_d = 4'h0; // R8
            end
            else if (count_q != 4'hF)
            begin
                // Saturate so a long excursion keeps firing
                count_d = count_q + 4'h1;
            end
            if (i_out_of_range && i_limit != 4'h0 && count_d >= i_limit)
            begin
                fire_d = 1'b1; // R7
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            count_q <= 4'h0;
            o_fire <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            o_fire <= fire_d;
        end
    end

endmodule

// ### rtl/pic_top.sv
// Proximity interrupt, pin routing and sleep-after-interrupt control
//
// Contract
// R1: Both crosstalk bits give ten-bit proximity format
// R2: One crosstalk bit alone changes nothing
// R3: Sleep enable stops oscillator on active interrupt
// R4: Host clears interrupts and sleep flag to resume
// R5: Interrupt pin source chosen by four-bit code
// R6: Auxiliary pin uses same code set
// R7: Interrupt after configured consecutive out-of-range samples
// R8: In-range sample resets persistence counter
// R9: Zero fires on every sample taken, reset value one
// R10: Inverted codes drive complement of combined interrupt
module pic_top
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_prox_valid,
    input wire logic [15:0] i_prox_result,
    input wire logic i_ambient_irq,
    input wire logic i_emitter_pulse,
    output logic o_ten_bit_mode,
    output logic o_osc_enable,
    output logic o_irq_n,
    output logic o_aux_pin
);

    logic high_crosstalk_enable_a_q;
    logic high_crosstalk_enable_b_q;
    logic sleep_after_irq_enable_q;
    logic prox_irq_enable_q;
    logic [3:0] irq_pin_select_q;
    logic [3:0] aux_pin_select_q;
    logic [3:0] proximity_persistence_count_q;
    logic [3:0] ambient_persistence_q;
    logic [15:0] proximity_low_threshold_q;
    logic [15:0] proximity_high_threshold_q;
    logic [15:0] proximity_result_q;
    logic proximity_irq_q;
    pic_pkg::pic_sleep_e sleep_q;
    pic_pkg::pic_sleep_e sleep_d;

    logic wr_mode;
    logic wr_routing;
    logic wr_persist;
    logic wr_control;
    logic wr_status;
    logic sample_taken;
    logic out_of_range;
    logic persist_fire;
    logic irq_any;
    logic normal_n;
    logic sleep_clear;
    logic [7:0] rdata_d;

    // Level that a pin shows for a given map code
    function automatic logic pin_level
    (
        input logic [3:0] sel,
        input logic norm_n,
        input logic amb,
        input logic prox,
        input logic pulse
    );
        logic lvl;
        lvl = 1'b1;
        case (sel)
            pic_pkg::PIC_PIN_NORMAL:
            begin
                lvl = norm_n;
            end
            pic_pkg::PIC_PIN_AMB_DIRECT:
            begin
                lvl = ~amb;
            end
            pic_pkg::PIC_PIN_PROX_DIRECT:
            begin
                lvl = ~prox;
            end
            pic_pkg::PIC_PIN_INVERTED_A,
            pic_pkg::PIC_PIN_INVERTED_B:
            begin
                lvl = ~norm_n; // R10
            end
            pic_pkg::PIC_PIN_EMITTER:
            begin
                lvl = pulse;
            end
            default:
            begin
                // Reserved codes park the pin inactive
                lvl = 1'b1;
            end
        endcase
        return lvl;
    endfunction

    // Address decode
    assign wr_mode = i_wr && i_addr == pic_pkg::PIC_ADDR_MODE_SLEEP;
    assign wr_routing = i_wr && i_addr == pic_pkg::PIC_ADDR_ROUTING;
    assign wr_persist = i_wr && i_addr == pic_pkg::PIC_ADDR_PERSIST;
    assign wr_control = i_wr && i_addr == pic_pkg::PIC_ADDR_CONTROL;
    assign wr_status = i_wr && i_addr == pic_pkg::PIC_ADDR_STATUS;

    // Mode and sleep configuration
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            high_crosstalk_enable_a_q <= 1'b0;
            sleep_after_irq_enable_q <= 1'b0;
        end
        else if (wr_mode)
        begin
            high_crosstalk_enable_a_q <= i_wdata[pic_pkg::PIC_HXTALK_A_BIT];
            sleep_after_irq_enable_q <= i_wdata[pic_pkg::PIC_SLEEP_EN_BIT];
        end
    end

    // Second crosstalk bit and proximity interrupt enable
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            high_crosstalk_enable_b_q <= 1'b0;
            prox_irq_enable_q <= 1'b0;
        end
        else if (wr_control)
        begin
            high_crosstalk_enable_b_q <= i_wdata[pic_pkg::PIC_HXTALK_B_BIT];
            prox_irq_enable_q <= i_wdata[pic_pkg::PIC_PROX_IEN_BIT];
        end
    end

    // Pin routing
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            irq_pin_select_q <= pic_pkg::PIC_SEL_RESET;
            aux_pin_select_q <= pic_pkg::PIC_SEL_RESET;
        end
        else if (wr_routing)
        begin
            irq_pin_select_q <= i_wdata[pic_pkg::PIC_IRQ_SEL_LSB +: 4];
            aux_pin_select_q <= i_wdata[pic_pkg::PIC_AUX_SEL_LSB +: 4];
        end
    end

    // Persistence; the ambient nibble is storage only here
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            proximity_persistence_count_q <= pic_pkg::PIC_PROXIMITY_PERSISTENCE_COUNT_RESET; // R9
            ambient_persistence_q <= pic_pkg::PIC_APERS_RESET;
        end
        else if (wr_persist)
        begin
            proximity_persistence_count_q <=
                i_wdata[pic_pkg::PIC_PROXIMITY_PERSISTENCE_COUNT_LSB +: 4];
            ambient_persistence_q <= i_wdata[pic_pkg::PIC_APERS_LSB +: 4];
        end
    end

    // Thresholds, written a byte at a time
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            proximity_low_threshold_q <= pic_pkg::PIC_LOW_THR_RESET;
            proximity_high_threshold_q <= pic_pkg::PIC_HIGH_THR_RESET;
        end
        else if (i_wr)
        begin
            case (i_addr)
                pic_pkg::PIC_ADDR_LOW_THR_LO:
                begin
                    proximity_low_threshold_q[7:0] <= i_wdata;
                end
                pic_pkg::PIC_ADDR_LOW_THR_HI:
                begin
                    proximity_low_threshold_q[15:8] <= i_wdata;
                end
                pic_pkg::PIC_ADDR_HIGH_THR_LO:
                begin
                    proximity_high_threshold_q[7:0] <= i_wdata;
                end
                pic_pkg::PIC_ADDR_HIGH_THR_HI:
                begin
                    proximity_high_threshold_q[15:8] <= i_wdata;
                end
                default:
                begin
                end
            endcase
        end
    end

    // A stopped oscillator means the engine delivers no samples
    assign sample_taken = i_prox_valid && o_osc_enable;
    assign out_of_range = i_prox_result < proximity_low_threshold_q
        || i_prox_result > proximity_high_threshold_q;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            proximity_result_q <= 16'h0000;
        end
        else if (sample_taken)
        begin
            proximity_result_q <= i_prox_result;
        end
    end

    pic_persist u_persist
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_sample_valid(sample_taken),
        .i_out_of_range(out_of_range),
        .i_limit(proximity_persistence_count_q),
        .o_fire(persist_fire)
    );

    // Sticky proximity interrupt; a new event beats a clear
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            proximity_irq_q <= 1'b0;
        end
        else if (persist_fire)
        begin
            proximity_irq_q <= 1'b1; // R7
        end
        else if (wr_status && i_wdata[pic_pkg::PIC_ST_PROX_BIT])
        begin
            proximity_irq_q <= 1'b0;
        end
    end

    assign irq_any = (proximity_irq_q && prox_irq_enable_q) || i_ambient_irq;
    assign normal_n = ~irq_any;
    assign sleep_clear = wr_status && i_wdata[pic_pkg::PIC_ST_SLEEP_BIT];

    // Sleep state: entering wins over a clear in the same cycle
    always_comb
    begin
        sleep_d = sleep_q;
        case (sleep_q)
            pic_pkg::PIC_RUN:
            begin
                if (sleep_after_irq_enable_q && irq_any)
                begin
                    sleep_d = pic_pkg::PIC_SLEEP; // R3
                end
            end
            pic_pkg::PIC_SLEEP:
            begin
                if (sleep_clear && !irq_any)
                begin
                    sleep_d = pic_pkg::PIC_RUN; // R4
                end
            end
            default:
            begin
                sleep_d = pic_pkg::PIC_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sleep_q <= pic_pkg::PIC_RUN;
        end
        else
        begin
            sleep_q <= sleep_d;
        end
    end

    // Oscillator runs only while awake and no interrupt holds it
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_osc_enable <= 1'b1;
        end
        else
        begin
            o_osc_enable <= !(sleep_d == pic_pkg::PIC_SLEEP
                || (sleep_after_irq_enable_q && irq_any)); // R3
        end
    end

    // Output format needs both bits; either alone is ignored
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_ten_bit_mode <= 1'b0;
        end
        else
        begin
            o_ten_bit_mode <= high_crosstalk_enable_a_q
                && high_crosstalk_enable_b_q; // R1 R2
        end
    end

    // Pin drivers
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_irq_n <= 1'b1;
            o_aux_pin <= 1'b1;
        end
        else
        begin
            o_irq_n <= pin_level(irq_pin_select_q, normal_n, i_ambient_irq,
                proximity_irq_q, i_emitter_pulse); // R5
            o_aux_pin <= pin_level(aux_pin_select_q, normal_n,
                i_ambient_irq, proximity_irq_q, i_emitter_pulse); // R6
        end
    end

    // Register read mux
    always_comb
    begin
        rdata_d = pic_pkg::PIC_RDATA_IDLE;
        case (i_addr)
            pic_pkg::PIC_ADDR_MODE_SLEEP:
            begin
                rdata_d = {pic_pkg::PIC_MODE_TOP_VAL,
                    high_crosstalk_enable_a_q, sleep_after_irq_enable_q,
                    pic_pkg::PIC_MODE_RSVD_VAL};
            end
            pic_pkg::PIC_ADDR_ROUTING:
            begin
                rdata_d = {irq_pin_select_q, aux_pin_select_q};
            end
            pic_pkg::PIC_ADDR_PERSIST:
            begin
                rdata_d = {proximity_persistence_count_q,
                    ambient_persistence_q};
            end
            pic_pkg::PIC_ADDR_CONTROL:
            begin
                rdata_d = {6'h00, prox_irq_enable_q,
                    high_crosstalk_enable_b_q};
            end
            pic_pkg::PIC_ADDR_STATUS:
            begin
                rdata_d = {5'h00, sleep_q == pic_pkg::PIC_SLEEP,
                    i_ambient_irq, proximity_irq_q};
            end
            pic_pkg::PIC_ADDR_LOW_THR_LO:
            begin
                rdata_d = proximity_low_threshold_q[7:0];
            end
            pic_pkg::PIC_ADDR_LOW_THR_HI:
            begin
                rdata_d = proximity_low_threshold_q[15:8];
            end
            pic_pkg::PIC_ADDR_HIGH_THR_LO:
            begin
                rdata_d = proximity_high_threshold_q[7:0];
            end
            pic_pkg::PIC_ADDR_HIGH_THR_HI:
            begin
                rdata_d = proximity_high_threshold_q[15:8];
            end
            pic_pkg::PIC_ADDR_RESULT_LO:
            begin
                rdata_d = proximity_result_q[7:0];
            end
            pic_pkg::PIC_ADDR_RESULT_HI:
            begin
                rdata_d = proximity_result_q[15:8];
            end
            default:
            begin
                rdata_d = pic_pkg::PIC_RDATA_IDLE;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_rdata <= pic_pkg::PIC_RDATA_IDLE;
        end
        else if (i_rd)
        begin
            o_rdata <= rdata_d;
        end
        else
        begin
            o_rdata <= pic_pkg::PIC_RDATA_IDLE;
        end
    end

endmodule

// ### verif/pic_top_assertions.sv
// Port checker for the proximity interrupt and pin routing logic
module pic_top_assertions
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_ambient_irq,
    input wire logic i_emitter_pulse,
    input wire logic o_ten_bit_mode,
    input wire logic o_osc_enable,
    input wire logic o_irq_n,
    input wire logic o_aux_pin
);
    logic [3:0] isel_q;
    logic [3:0] asel_q;
    logic xa_q;
    logic xb_q;
    logic sen_q;

    // Shadow of bus-written fields, taken at the write edge
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            isel_q <= 4'h0;
            asel_q <= 4'h0;
            xa_q <= 1'b0;
            xb_q <= 1'b0;
            sen_q <= 1'b0;
        end
        else if (i_wr)
        begin
            if (i_addr == pic_pkg::PIC_ADDR_MODE_SLEEP)
            begin
                xa_q <= i_wdata[5];
                sen_q <= i_wdata[4];
            end
            if (i_addr == pic_pkg::PIC_ADDR_ROUTING)
            begin
                isel_q <= i_wdata[7:4];
                asel_q <= i_wdata[3:0];
            end
            if (i_addr == pic_pkg::PIC_ADDR_CONTROL)
                xb_q <= i_wdata[0];
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    ten_bit_a: assert property (o_ten_bit_mode == $past(xa_q & xb_q))
        else $error("ten bit mode wrong");
    sleep_stop_a: assert property (sen_q && isel_q == 4'h0 && !o_irq_n
        |-> ##[0:2] !o_osc_enable)
        else $error("oscillator kept running");
    osc_resume_a: assert property ($rose(o_osc_enable) |-> $past(i_wr, 1)
        && $past(i_addr, 1) == pic_pkg::PIC_ADDR_STATUS
        && $past(i_wdata[2], 1))
        else $error("oscillator resumed without flag clear");
    irq_pulse_a: assert property ($past(isel_q) == 4'h6
        |-> o_irq_n == $past(i_emitter_pulse))
        else $error("irq pin not emitter pulse");
    aux_pulse_a: assert property ($past(asel_q) == 4'h6
        |-> o_aux_pin == $past(i_emitter_pulse))
        else $error("aux pin not emitter pulse");
    irq_amb_a: assert property ($past(isel_q) == 4'h2
        |-> o_irq_n == !$past(i_ambient_irq))
        else $error("irq pin not ambient");
    irq_rsvd_a: assert property ($past(isel_q) inside {4'h1, [4'h7:4'hF]}
        |-> o_irq_n)
        else $error("reserved code drives low");
    inverted_pin_a: assert property ($past(isel_q) inside {4'h4, 4'h5}
        && $past(asel_q) == 4'h0 |-> o_irq_n != o_aux_pin)
        else $error("inverted code not complement");

    cover property ($fell(o_osc_enable));
    cover property ($rose(o_ten_bit_mode));
    cover property ($past(isel_q) == 4'h4 && $past(asel_q) == 4'h0);
endmodule

bind pic_top pic_top_assertions chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ambient_irq(i_ambient_irq),
    .i_emitter_pulse(i_emitter_pulse), .o_ten_bit_mode(o_ten_bit_mode),
    .o_osc_enable(o_osc_enable), .o_irq_n(o_irq_n), .o_aux_pin(o_aux_pin));

// ### verif/pic_host_model.sv
// Host processor model: register bus master and interrupt service
module pic_host_model
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // Released bus must not look like a held request
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask

    // Pending proximity flag first, sleep flag once no interrupt is left
    task automatic service();
        wr(pic_pkg::PIC_ADDR_STATUS, 8'h01);
        wr(pic_pkg::PIC_ADDR_STATUS, 8'h04);
    endtask
endmodule

// ### verif/pic_top_bench.sv
// Self-checking bench for pic_top
module pic_top_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk;
    logic i_resetn;
    logic i_prox_valid;
    logic [15:0] i_prox_result;
    logic i_ambient_irq;
    logic i_emitter_pulse;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic ten;
    logic osc;
    logic irq_n;
    logic aux;
    int n_errors;
    int checks_done;

    pic_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_prox_valid(i_prox_valid), .i_prox_result(i_prox_result),
        .i_ambient_irq(i_ambient_irq), .i_emitter_pulse(i_emitter_pulse),
        .o_ten_bit_mode(ten), .o_osc_enable(osc), .o_irq_n(irq_n),
        .o_aux_pin(aux));

    pic_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(16'(d), 16'(exp));
    endtask

    task automatic sample(input logic [15:0] r);
        @(posedge i_clk);
        i_prox_valid <= 1'b1;
        i_prox_result <= r;
        @(posedge i_clk);
        i_prox_valid <= 1'b0;
        i_prox_result <= ~r;
        tick(2);
    endtask

    task automatic t_reset();
        chk(16'({ten, osc, irq_n, aux}), 16'h7);
        rchk(pic_pkg::PIC_ADDR_MODE_SLEEP, 8'h0F);
        rchk(pic_pkg::PIC_ADDR_ROUTING, 8'h00);
        rchk(pic_pkg::PIC_ADDR_PERSIST, 8'h11);
        rchk(8'h50, 8'h00);
    endtask

    task automatic t_xtalk();
        host.wr(pic_pkg::PIC_ADDR_MODE_SLEEP, 8'h20);
        tick(2);
        chk(16'(ten), 16'h0);
        host.wr(pic_pkg::PIC_ADDR_CONTROL, 8'h01);
        tick(2);
        chk(16'(ten), 16'h1);
        rchk(pic_pkg::PIC_ADDR_MODE_SLEEP, 8'h2F);
        host.wr(pic_pkg::PIC_ADDR_MODE_SLEEP, 8'h00);
        tick(2);
        chk(16'(ten), 16'h0);
    endtask

    task automatic t_persist();
        host.wr(pic_pkg::PIC_ADDR_LOW_THR_LO, 8'h10);
        host.wr(pic_pkg::PIC_ADDR_HIGH_THR_LO, 8'h20);
        host.wr(pic_pkg::PIC_ADDR_HIGH_THR_HI, 8'h00);
        host.wr(pic_pkg::PIC_ADDR_CONTROL, 8'h02);
        host.wr(pic_pkg::PIC_ADDR_PERSIST, 8'h31);
        sample(16'h0005);
        sample(16'h0030);
        sample(16'h0010);
        sample(16'h0005);
        sample(16'h0021);
        rchk(pic_pkg::PIC_ADDR_STATUS, 8'h00);
        sample(16'h0021);
        rchk(pic_pkg::PIC_ADDR_STATUS, 8'h01);
        chk(16'(irq_n), 16'h0);
        rchk(pic_pkg::PIC_ADDR_RESULT_LO, 8'h21);
        rchk(pic_pkg::PIC_ADDR_HIGH_THR_LO, 8'h20);
        host.wr(pic_pkg::PIC_ADDR_STATUS, 8'h01);
        host.wr(pic_pkg::PIC_ADDR_PERSIST, 8'h01);
        sample(16'h0018);
        rchk(pic_pkg::PIC_ADDR_STATUS, 8'h01);
        host.wr(pic_pkg::PIC_ADDR_STATUS, 8'h01);
        host.wr(pic_pkg::PIC_ADDR_PERSIST, 8'h11);
        sample(16'h0018);
        rchk(pic_pkg::PIC_ADDR_STATUS, 8'h00);
    endtask

    // Pending and enabled, ambient low: combined level is active
    task automatic t_pins();
        logic e;
        sample(16'h0040);
        for (int c = 0; c < 16; c++)
        begin
            e = !(c == 0 || c == 3 || c == 6);
            host.wr(pic_pkg::PIC_ADDR_ROUTING, {c[3:0], 4'h0});
            tick(2);
            chk(16'({irq_n, aux}), 16'({e, 1'b0}));
            host.wr(pic_pkg::PIC_ADDR_ROUTING, {4'h0, c[3:0]});
            tick(2);
            chk(16'({irq_n, aux}), 16'({1'b0, e}));
        end
        host.wr(pic_pkg::PIC_ADDR_ROUTING, 8'h66);
        i_emitter_pulse <= 1'b1;
        tick(3);
        chk(16'({irq_n, aux}), 16'h3);
        host.wr(pic_pkg::PIC_ADDR_ROUTING, 8'h23);
        i_ambient_irq <= 1'b1;
        tick(3);
        chk(16'({irq_n, aux}), 16'h0);
        i_ambient_irq <= 1'b0;
        i_emitter_pulse <= 1'b0;
        host.wr(pic_pkg::PIC_ADDR_ROUTING, 8'h00);
        host.wr(pic_pkg::PIC_ADDR_STATUS, 8'h01);
    endtask

    task automatic t_sleep();
        host.wr(pic_pkg::PIC_ADDR_MODE_SLEEP, 8'h10);
        sample(16'h0040);
        tick(1);
        chk(16'(osc), 16'h0);
        rchk(pic_pkg::PIC_ADDR_STATUS, 8'h05);
        host.wr(pic_pkg::PIC_ADDR_STATUS, 8'h04);
        tick(2);
        chk(16'(osc), 16'h0);
        host.service();
        tick(2);
        chk(16'(osc), 16'h1);
        rchk(pic_pkg::PIC_ADDR_STATUS, 8'h00);
    endtask

    initial
    begin
        n_errors = 0;
        checks_done = 0;
        i_resetn = 1'b0;
        i_prox_valid = 1'b0;
        i_prox_result = 16'h0000;
        i_ambient_irq = 1'b0;
        i_emitter_pulse = 1'b0;
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        tick(1);
        t_reset();
        t_xtalk();
        t_persist();
        t_pins();
        t_sleep();
        stop_test();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        #40000;
        n_errors++;
        stop_test();
    end
endmodule
